// ---- core/cpgo_c13_path.sv ----
// channel 13 digital gain and offset stage, one register of latency
// assumes signed samples synchronous to ref_clk and settings held stable
`timescale 1ns/1ps
module cpgo_c13_path #(
    parameter int unsigned DATA_W = 14,
    parameter int unsigned GAIN_W = 5,
    parameter int unsigned OFS_W  = 10
) (
    input  wire logic                     ref_clk,
    input  wire logic                     sys_rst,
    input  wire logic signed [DATA_W-1:0] sample_in,
    input  wire logic                     sample_valid,
    input  wire logic                     digital_gain_enable,
    input  wire logic                     digital_offset_enable,
    input  wire logic        [GAIN_W-1:0] c13_digital_gain,
    input  wire logic signed [OFS_W-1:0]  c13_digital_offset,
    output logic signed      [DATA_W-1:0] sample_out,
    output logic                          sample_out_valid,
    output logic                          saturated
);
    import cpgo_pkg::*;

    localparam int unsigned PROD_W = DATA_W + 15;
    localparam int unsigned SUM_W  = DATA_W + 4;

    // 10^(N*0.2/20) in Q12, N = 0..31
    function automatic logic [14:0] gain_factor(input logic [4:0] n);
        logic [14:0] f;
        f = 15'h1000;
        case (n)
            5'h00: f = 15'd4096;  5'h01: f = 15'd4191;  5'h02: f = 15'd4289;  5'h03: f = 15'd4389;
            5'h04: f = 15'd4491;  5'h05: f = 15'd4596;  5'h06: f = 15'd4703;  5'h07: f = 15'd4812;
            5'h08: f = 15'd4924;  5'h09: f = 15'd5039;  5'h0A: f = 15'd5157;  5'h0B: f = 15'd5277;
            5'h0C: f = 15'd5400;  5'h0D: f = 15'd5525;  5'h0E: f = 15'd5654;  5'h0F: f = 15'd5786;
            5'h10: f = 15'd5921;  5'h11: f = 15'd6058;  5'h12: f = 15'd6200;  5'h13: f = 15'd6344;
            5'h14: f = 15'd6492;  5'h15: f = 15'd6643;  5'h16: f = 15'd6798;  5'h17: f = 15'd6956;
            5'h18: f = 15'd7118;  5'h19: f = 15'd7284;  5'h1A: f = 15'd7453;  5'h1B: f = 15'd7627;
            5'h1C: f = 15'd7805;  5'h1D: f = 15'd7987;  5'h1E: f = 15'd8173;  5'h1F: f = 15'd8363;
            default: f = 15'h1000;
        endcase
        return f;
    endfunction : gain_factor

    logic        [14:0]       factor;
    logic signed [PROD_W-1:0] product;
    logic signed [SUM_W-1:0]  next_sum;
    logic signed [DATA_W-1:0] next_out;
    logic                     next_sat;

    always_comb begin
        factor = digital_gain_enable ? gain_factor(c13_digital_gain) : 15'h1000;
        product = PROD_W'(sample_in) * $signed({1'b0, factor[13:0]});
        next_sum = SUM_W'(product >>> CPGO_GAIN_FRAC);
        if (digital_offset_enable) begin
            next_sum = next_sum + SUM_W'(c13_digital_offset);
        end
        next_sat = 1'b0;
        next_out = next_sum[DATA_W-1:0];
        // clip rather than wrap, a wrapped echo reads as a bright artefact
        if (next_sum > SUM_W'(2**(DATA_W-1) - 1)) begin
            next_out = {1'b0, {(DATA_W-1){1'b1}}};
            next_sat = 1'b1;
        end else if (next_sum < -SUM_W'(2**(DATA_W-1))) begin
            next_out = {1'b1, {(DATA_W-1){1'b0}}};
            next_sat = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sample_out <= '0;
            saturated <= 1'b0;
        end else if (sample_valid) begin
            sample_out <= next_out;
            saturated <= next_sat;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sample_out_valid <= 1'b0;
        end else begin
            sample_out_valid <= sample_valid;
        end
    end

endmodule : cpgo_c13_path

// ---- core/cpgo_regs.sv ----
// power-down, output inversion, channel 13 gain and offset register bank
// assumes a wishbone classic master on ref_clk; samples are synchronous
`timescale 1ns/1ps
module cpgo_regs #(
    parameter int unsigned DATA_W  = 14,
    parameter int unsigned LINES   = 4,
    parameter int unsigned GAIN_W  = 5,
    parameter int unsigned OFS_W   = 10
) (
    input  wire logic                          ref_clk,
    input  wire logic                          sys_rst,
    // wishbone classic slave
    input  wire logic [cpgo_pkg::CPGO_ADDR_W-1:0] wb_adr_i,
    input  wire logic [31:0]                   wb_dat_i,
    input  wire logic [3:0]                    wb_sel_i,
    input  wire logic                          wb_we_i,
    input  wire logic                          wb_cyc_i,
    input  wire logic                          wb_stb_i,
    output logic      [31:0]                   wb_dat_o,
    output logic                               wb_ack_o,
    // channel 9..12 controls, bit 0 is channel or line 9
    output logic      [LINES-1:0]              digital_sleep,
    output logic      [LINES-1:0]              line_sleep,
    output logic      [LINES-1:0]              analog_sleep,
    // channel 9..12 output lines
    input  wire logic [LINES*DATA_W-1:0]       line_data_in,
    input  wire logic [LINES-1:0]              line_pattern_mode,
    output logic      [LINES*DATA_W-1:0]       line_data_out,
    // channel 13 sample path
    input  wire logic [DATA_W-1:0]             c13_sample_in,
    input  wire logic                          c13_sample_valid,
    output logic      [DATA_W-1:0]             c13_sample_out,
    output logic                               c13_sample_out_valid
);
    import cpgo_pkg::*;

    // stored registers
    logic [CPGO_REG_W-1:0]  pwr_ctrl;
    logic [CPGO_REG_W-1:0]  gain_ofs;
    logic [CPGO_REG_W-1:0]  ofs_copy;
    logic [1:0]             ctrl;

    // bus side
    cpgo_bus_state_t        bus_state;
    cpgo_bus_state_t        next_bus_state;
    logic                   bus_req;
    logic                   wr_take;
    logic [7:0]             req_idx;
    logic                   aligned;
    logic [31:0]            next_rd_data;

    // decoded fields
    logic                   digital_gain_enable;
    logic                   digital_offset_enable;
    logic [GAIN_W-1:0]      c13_digital_gain;
    logic [OFS_W-1:0]       c13_digital_offset;
    logic [OFS_W-1:0]       c13_offset_copy;
    logic                   copies_differ;
    logic                   c13_saturated;

    // index match, only on word-aligned addresses inside the decoded page
    function automatic logic hits(
        input logic [CPGO_ADDR_W-1:0] adr,
        input logic [7:0]             idx
    );
        logic ok;
        ok = (adr[1:0] == 2'h0) && (adr[CPGO_ADDR_W-1:10] == '0);
        return ok && (adr[9:2] == idx);
    endfunction : hits

    // byte-lane merge of a 16-bit register, lanes 2 and 3 carry nothing
    function automatic logic [CPGO_REG_W-1:0] merge16(
        input logic [CPGO_REG_W-1:0] old_val,
        input logic [31:0]           wdat,
        input logic [3:0]            sel
    );
        logic [CPGO_REG_W-1:0] v;
        v = old_val;
        if (sel[0]) begin
            v[7:0] = wdat[7:0];
        end
        if (sel[1]) begin
            v[15:8] = wdat[15:8];
        end
        return v;
    endfunction : merge16

    assign bus_req = wb_cyc_i && wb_stb_i;
    assign req_idx = wb_adr_i[9:2];
    assign aligned = (wb_adr_i[1:0] == 2'h0);

    // one wait state, ack in the cycle after the request is seen
    always_comb begin
        next_bus_state = bus_state;
        case (bus_state)
            CPGO_BUS_IDLE: begin
                if (bus_req) begin
                    next_bus_state = CPGO_BUS_ACK;
                end
            end
            CPGO_BUS_ACK: begin
                next_bus_state = CPGO_BUS_IDLE;
            end
            default: begin
                next_bus_state = CPGO_BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            bus_state <= CPGO_BUS_IDLE;
        end else begin
            bus_state <= next_bus_state;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= (bus_state == CPGO_BUS_IDLE) && bus_req;
        end
    end

    // writes land on the edge that raises ack, exactly once per request
    assign wr_take = (bus_state == CPGO_BUS_IDLE) && bus_req && wb_we_i;

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pwr_ctrl <= CPGO_PWR_RST;
        end else if (wr_take && hits(wb_adr_i, CPGO_IDX_PWR)) begin
            pwr_ctrl <= merge16(pwr_ctrl, wb_dat_i, wb_sel_i);
        end
    end

    // unused bits are stored as written; software keeps them zero
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            gain_ofs <= CPGO_GAIN_OFS_RST;
        end else if (wr_take && hits(wb_adr_i, CPGO_IDX_GAIN_OFS)) begin
            gain_ofs <= merge16(gain_ofs, wb_dat_i, wb_sel_i);
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ofs_copy <= CPGO_OFS_COPY_RST;
        end else if (wr_take && hits(wb_adr_i, CPGO_IDX_OFS_COPY)) begin
            ofs_copy <= merge16(ofs_copy, wb_dat_i, wb_sel_i);
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl <= CPGO_CTRL_RST;
        end else if (wr_take && hits(wb_adr_i, CPGO_IDX_CTRL) && wb_sel_i[0]) begin
            ctrl <= wb_dat_i[1:0];
        end
    end

    // read mux, unmapped or misaligned addresses read zero
    always_comb begin
        next_rd_data = 32'h0000_0000;
        if (aligned && (wb_adr_i[CPGO_ADDR_W-1:10] == '0)) begin
            case (req_idx)
                CPGO_IDX_PWR: begin
                    next_rd_data = {16'h0000, pwr_ctrl};
                end
                CPGO_IDX_GAIN_OFS: begin
                    next_rd_data = {16'h0000, gain_ofs};
                end
                CPGO_IDX_OFS_COPY: begin
                    next_rd_data = {16'h0000, ofs_copy};
                end
                CPGO_IDX_CTRL: begin
                    next_rd_data = {30'h0000_0000, ctrl};
                end
                CPGO_IDX_STATUS: begin
                    next_rd_data = {30'h0000_0000, c13_saturated, copies_differ};
                end
                default: begin
                    next_rd_data = 32'h0000_0000;
                end
            endcase
        end
    end

    // read data is captured with ack so it stands only while ack does
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wb_dat_o <= 32'h0000_0000;
        end else if ((bus_state == CPGO_BUS_IDLE) && bus_req && !wb_we_i) begin
            wb_dat_o <= next_rd_data;
        end else begin
            wb_dat_o <= 32'h0000_0000;
        end
    end

    // field decode
    assign digital_gain_enable   = ctrl[CPGO_CTRL_GAIN_EN];
    assign digital_offset_enable = ctrl[CPGO_CTRL_OFS_EN];
    assign c13_digital_gain      = gain_ofs[CPGO_GAIN_LSB +: GAIN_W];
    assign c13_digital_offset    = gain_ofs[CPGO_OFS_LSB +: OFS_W];
    assign c13_offset_copy       = ofs_copy[CPGO_OFS_LSB +: OFS_W];

    // the copy is only checked, the data path uses the first register;
    // a mismatch means software skipped half of a paired update
    assign copies_differ = (c13_digital_offset != c13_offset_copy);

    // power-down levels, registered so they never glitch the supplies
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            digital_sleep <= '0;
        end else begin
            digital_sleep <= pwr_ctrl[CPGO_DSLEEP_LSB +: LINES];
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            line_sleep <= '0;
        end else begin
            line_sleep <= pwr_ctrl[CPGO_LSLEEP_LSB +: LINES];
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            analog_sleep <= '0;
        end else begin
            analog_sleep <= pwr_ctrl[CPGO_ASLEEP_LSB +: LINES];
        end
    end

    // per-line output stage
    for (genvar i = 0; i < LINES; i++) begin : g_line
        logic [DATA_W-1:0] raw;
        logic [DATA_W-1:0] next_word;
        logic              flip;

        assign raw  = line_data_in[i*DATA_W +: DATA_W];
        assign flip = pwr_ctrl[CPGO_FLIP_LSB + i];

        always_comb begin
            next_word = raw;
            if (pwr_ctrl[CPGO_LSLEEP_LSB + i] || pwr_ctrl[CPGO_DSLEEP_LSB + i]) begin
                // a sleeping line or a channel in digital sleep sends nothing
                next_word = '0;
            end else if (line_pattern_mode[i]) begin
                next_word = raw;
            end else if (flip) begin
                next_word = ~raw;
            end
        end

        always_ff @(posedge ref_clk or posedge sys_rst) begin
            if (sys_rst) begin
                line_data_out[i*DATA_W +: DATA_W] <= '0;
            end else begin
                line_data_out[i*DATA_W +: DATA_W] <= next_word;
            end
        end
    end

    cpgo_c13_path #(
        .DATA_W (DATA_W),
        .GAIN_W (GAIN_W),
        .OFS_W  (OFS_W)
    ) u_c13 (
        .ref_clk               (ref_clk),
        .sys_rst               (sys_rst),
        .sample_in             (c13_sample_in),
        .sample_valid          (c13_sample_valid),
        .digital_gain_enable   (digital_gain_enable),
        .digital_offset_enable (digital_offset_enable),
        .c13_digital_gain      (c13_digital_gain),
        .c13_digital_offset    (c13_digital_offset),
        .sample_out            (c13_sample_out),
        .sample_out_valid      (c13_sample_out_valid),
        .saturated             (c13_saturated)
    );

endmodule : cpgo_regs

// ---- pkg/cpgo_pkg.sv ----
// constants shared by the channel power, gain and offset register bank
// assumes a wishbone classic master with 32-bit data and byte addresses
package cpgo_pkg;

    // register indices; byte address is four times the index
    localparam logic [7:0]  CPGO_IDX_PWR      = 8'h30;
    localparam logic [7:0]  CPGO_IDX_GAIN_OFS = 8'h31;
    localparam logic [7:0]  CPGO_IDX_OFS_COPY = 8'h32;
    localparam logic [7:0]  CPGO_IDX_CTRL     = 8'h40;
    localparam logic [7:0]  CPGO_IDX_STATUS   = 8'h41;

    localparam int unsigned CPGO_ADDR_W       = 12;
    localparam int unsigned CPGO_REG_W        = 16;

    // field positions
    localparam int unsigned CPGO_DSLEEP_LSB   = 12;
    localparam int unsigned CPGO_LSLEEP_LSB   = 8;
    localparam int unsigned CPGO_ASLEEP_LSB   = 4;
    localparam int unsigned CPGO_FLIP_LSB     = 0;
    localparam int unsigned CPGO_GAIN_LSB     = 11;
    localparam int unsigned CPGO_OFS_LSB      = 0;
    localparam int unsigned CPGO_CTRL_GAIN_EN = 0;
    localparam int unsigned CPGO_CTRL_OFS_EN  = 1;
    localparam int unsigned CPGO_STAT_DIFFER  = 0;
    localparam int unsigned CPGO_STAT_SAT     = 1;

    // values after reset
    localparam logic [15:0] CPGO_PWR_RST      = 16'h0000;
    localparam logic [15:0] CPGO_GAIN_OFS_RST = 16'h0000;
    localparam logic [15:0] CPGO_OFS_COPY_RST = 16'h0000;
    localparam logic [1:0]  CPGO_CTRL_RST     = 2'h0;

    // gain multiplier is unsigned fixed point with this many fraction bits
    localparam int unsigned CPGO_GAIN_FRAC    = 12;

    typedef enum logic [1:0] {
        CPGO_BUS_IDLE = 2'b01,
        CPGO_BUS_ACK  = 2'b10
    } cpgo_bus_state_t;

endpackage : cpgo_pkg

// ---- tb/cpgo_regs_sva.sv ----
// concurrent checks for the channel power, gain and offset register bank
// assumes wishbone classic stimulus and the bind at the foot of this file
`timescale 1ns/1ps
module cpgo_regs_sva #(
    parameter int unsigned DATA_W = 14,
    parameter int unsigned LINES  = 4
) (
    input wire logic                             ref_clk,
    input wire logic                             sys_rst,
    input wire logic [cpgo_pkg::CPGO_ADDR_W-1:0] wb_adr_i,
    input wire logic [31:0]                      wb_dat_i,
    input wire logic [3:0]                       wb_sel_i,
    input wire logic                             wb_we_i,
    input wire logic                             wb_cyc_i,
    input wire logic                             wb_stb_i,
    input wire logic [31:0]                      wb_dat_o,
    input wire logic                             wb_ack_o,
    input wire logic [LINES-1:0]                 digital_sleep,
    input wire logic [LINES-1:0]                 line_sleep,
    input wire logic [LINES-1:0]                 analog_sleep,
    input wire logic [LINES*DATA_W-1:0]          line_data_in,
    input wire logic [LINES-1:0]                 line_pattern_mode,
    input wire logic [LINES*DATA_W-1:0]          line_data_out,
    input wire logic [DATA_W-1:0]                c13_sample_in,
    input wire logic                             c13_sample_valid,
    input wire logic [DATA_W-1:0]                c13_sample_out,
    input wire logic                             c13_sample_out_valid
);
    import cpgo_pkg::*;
    localparam logic signed [DATA_W+1:0] SMAX = 2**(DATA_W-1)-1;
    logic [15:0]              pwr;
    logic [15:0]              gofs;
    logic [1:0]               ctrl;
    logic                     armed;
    logic signed [DATA_W+1:0] ofs_sum;
    logic [DATA_W-1:0]        ofs_exp;
    wire       take  = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire       wr    = take && wb_we_i;
    wire [15:0] wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    // shadow copies let the outputs be judged against what was written
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pwr   <= CPGO_PWR_RST;
            gofs  <= CPGO_GAIN_OFS_RST;
            ctrl  <= CPGO_CTRL_RST;
            armed <= 1'b0;
        end else begin
            armed <= 1'b1;
            if (wr && wb_adr_i == 12'h0C0) pwr <= (pwr & ~wmask) | (wb_dat_i[15:0] & wmask);
            if (wr && wb_adr_i == 12'h0C4) gofs <= (gofs & ~wmask) | (wb_dat_i[15:0] & wmask);
            if (wr && wb_adr_i == 12'h100 && wb_sel_i[0]) ctrl <= wb_dat_i[1:0];
        end
    end

    always_comb begin
        ofs_sum = $signed(c13_sample_in) + $signed(gofs[9:0]);
        if (ofs_sum > SMAX) ofs_exp = SMAX[DATA_W-1:0];
        else if (ofs_sum < -SMAX-1) ofs_exp = {1'b1, {(DATA_W-1){1'b0}}};
        else ofs_exp = ofs_sum[DATA_W-1:0];
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    a_ack_next: assert property (take |=> wb_ack_o)
        else $error("no acknowledge one cycle after request");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("acknowledge longer than one cycle");
    a_read_power: assert property (take && !wb_we_i && wb_adr_i == 12'h0C0 |=> wb_dat_o == {16'h0000, pwr})
        else $error("power register read back wrong");
    a_read_gainofs: assert property (take && !wb_we_i && wb_adr_i == 12'h0C4 |=> wb_dat_o == {16'h0000, gofs})
        else $error("gain offset register read back wrong");
    a_dsleep_map: assert property (armed |-> digital_sleep == $past(pwr[15:12]))
        else $error("digital sleep outputs differ from register");
    a_lsleep_map: assert property (armed |-> line_sleep == $past(pwr[11:8]))
        else $error("line sleep outputs differ from register");
    a_asleep_map: assert property (armed |-> analog_sleep == $past(pwr[7:4]))
        else $error("analog sleep outputs differ from register");
    a_c13_valid: assert property (armed |-> c13_sample_out_valid == $past(c13_sample_valid))
        else $error("channel 13 valid not delayed by one");
    a_c13_plain: assert property (c13_sample_valid && ctrl == 2'b00 |=> c13_sample_out == $past(c13_sample_in))
        else $error("channel 13 altered with gain and offset off");
    a_c13_offset: assert property (c13_sample_valid && ctrl == 2'b10 |=> c13_sample_out == $past(ofs_exp))
        else $error("channel 13 offset result wrong");
    for (genvar i = 0; i < LINES; i++) begin : g_line
        a_line_value: assert property (armed |-> line_data_out[i*DATA_W +: DATA_W] ==
            ($past(pwr[8+i] | pwr[12+i]) ? '0 : ($past(pwr[i]) && !$past(line_pattern_mode[i])) ?
            ~$past(line_data_in[i*DATA_W +: DATA_W]) : $past(line_data_in[i*DATA_W +: DATA_W])))
            else $error("line output word wrong");
    end
endmodule : cpgo_regs_sva

bind cpgo_regs cpgo_regs_sva #(.DATA_W(DATA_W), .LINES(LINES)) u_sva (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
    .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .digital_sleep(digital_sleep), .line_sleep(line_sleep), .analog_sleep(analog_sleep),
    .line_data_in(line_data_in), .line_pattern_mode(line_pattern_mode), .line_data_out(line_data_out),
    .c13_sample_in(c13_sample_in), .c13_sample_valid(c13_sample_valid), .c13_sample_out(c13_sample_out),
    .c13_sample_out_valid(c13_sample_out_valid));

// ---- tb/cpgo_regs_tb.sv ----
// self-checking bench for the channel power, gain and offset register bank
// assumes default parameters: four lines of 14-bit words
`timescale 1ns/1ps
module cpgo_regs_tb;
    import cpgo_pkg::*;
    logic        ref_clk;
    logic        sys_rst;
    logic [11:0] wb_adr_i;
    logic [31:0] wb_dat_i;
    logic [3:0]  wb_sel_i;
    logic        wb_we_i;
    logic        wb_cyc_i;
    logic        wb_stb_i;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic [3:0]  digital_sleep;
    logic [3:0]  line_sleep;
    logic [3:0]  analog_sleep;
    logic [55:0] line_data_in;
    logic [3:0]  line_pattern_mode;
    logic [55:0] line_data_out;
    logic [13:0] c13_sample_in;
    logic        c13_sample_valid;
    logic [13:0] c13_sample_out;
    logic        c13_sample_out_valid;
    logic [31:0] rv;
    logic [14:0] sv;
    int          n_mismatch;
    int          comparisons;

    cpgo_regs DUT (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
        .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .digital_sleep(digital_sleep), .line_sleep(line_sleep), .analog_sleep(analog_sleep),
        .line_data_in(line_data_in), .line_pattern_mode(line_pattern_mode), .line_data_out(line_data_out),
        .c13_sample_in(c13_sample_in), .c13_sample_valid(c13_sample_valid), .c13_sample_out(c13_sample_out),
        .c13_sample_out_valid(c13_sample_out_valid));

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // one classic cycle; waits on ack as long as it takes, only the watchdog ends a hang
    task automatic wb(input logic [11:0] adr, input logic we, input logic [31:0] dat, input logic [3:0] sel);
        wb_adr_i <= adr;
        wb_we_i  <= we;
        wb_dat_i <= dat;
        wb_sel_i <= sel;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        do begin
            @(posedge ref_clk);
        end while (wb_ack_o !== 1'b1);
        rv = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
        @(posedge ref_clk);
    endtask : wb

    task automatic c13_send(input logic [13:0] x);
        c13_sample_in    <= x;
        c13_sample_valid <= 1'b1;
        @(posedge ref_clk);
        c13_sample_valid <= 1'b0;
        @(posedge ref_clk);
        sv = {c13_sample_out_valid, c13_sample_out};
    endtask : c13_send

    function automatic logic [55:0] line_exp(input logic [15:0] p, input logic [3:0] pat, input logic [55:0] d);
        logic [55:0] o;
        for (int i = 0; i < 4; i++) begin
            o[i*14 +: 14] = (p[8+i] | p[12+i]) ? 14'h0000 : (p[i] && !pat[i]) ? ~d[i*14 +: 14] : d[i*14 +: 14];
        end
        return o;
    endfunction : line_exp

    task automatic do_reset();
        sys_rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
    endtask : do_reset

    task automatic t_reset();
        check({digital_sleep, line_sleep, analog_sleep}, 64'h0);
        for (int a = 0; a < 3; a++) begin
            wb(12'h0C0 + 12'(4*a), 1'b0, 32'h0, 4'hF);
            check(rv, 64'h0);
        end
        $display("test reset values done");
    endtask : t_reset

    // walking one through every power and inversion bit, then byte enables
    task automatic t_power();
        logic [15:0] p;
        for (int b = 0; b < 16; b++) begin
            p = 16'h0001 << b;
            wb(12'h0C0, 1'b1, {16'hFFFF, p}, 4'hF);
            check({digital_sleep, line_sleep, analog_sleep}, {52'h0, p[15:4]});
            check(line_data_out, line_exp(p, 4'h0, line_data_in));
            wb(12'h0C0, 1'b0, 32'h0, 4'hF);
            check(rv, {16'h0000, p});
        end
        wb(12'h0C0, 1'b1, 32'h0000FFFF, 4'h1);
        wb(12'h0C0, 1'b0, 32'h0, 4'hF);
        check(rv, 32'h000080FF);
        wb(12'h0CC, 1'b1, 32'h0000FFFF, 4'hF);
        wb(12'h0CC, 1'b0, 32'h0, 4'hF);
        check(rv, 32'h0);
        wb(12'h0C1, 1'b0, 32'h0, 4'hF);
        check(rv, 32'h0);
        $display("test power bits done");
    endtask : t_power

    task automatic t_pattern();
        line_pattern_mode <= 4'b0101;
        wb(12'h0C0, 1'b1, 32'h0000000F, 4'hF);
        check(line_data_out, line_exp(16'h000F, 4'b0101, line_data_in));
        line_pattern_mode <= 4'b0000;
        $display("test pattern bypass done");
    endtask : t_pattern

    task automatic t_c13();
        wb(12'h0C4, 1'b1, {16'h0000, 5'd5, 1'b0, 10'h3F6}, 4'hF);
        wb(12'h0C8, 1'b1, 32'h000003F6, 4'hF);
        wb(12'h0C4, 1'b0, 32'h0, 4'hF);
        check(rv, 32'h00002BF6);
        wb(12'h0C8, 1'b0, 32'h0, 4'hF);
        check(rv, 32'h000003F6);
        c13_send(14'd1000);
        check(sv, {1'b1, 14'd1000});
        wb(12'h100, 1'b1, 32'h2, 4'hF);
        c13_send(14'd1000);
        check(sv, {1'b1, 14'd990});
        c13_send(14'h2002);
        check(sv, {1'b1, 14'h2000});
        wb(12'h104, 1'b0, 32'h0, 4'hF);
        check(rv, 32'h00000002);
        wb(12'h100, 1'b1, 32'h1, 4'hF);
        c13_send(14'd1000);
        check(sv, {1'b1, 14'd1122});
        $display("test channel 13 done");
    endtask : t_c13

    task automatic complete_run();
        $display("counts: comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : complete_run

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    // about 170 cycles expected; 10000 leaves ample room
    initial begin
        #1000000;
        n_mismatch++;
        complete_run();
    end

    initial begin
        n_mismatch = 0;
        comparisons = 0;
        sys_rst = 1'b1;
        {wb_adr_i, wb_dat_i, wb_sel_i, wb_we_i, wb_cyc_i, wb_stb_i} = '0;
        line_data_in = {14'h3FFE, 14'h2AAA, 14'h1F00, 14'h0155};
        line_pattern_mode = 4'h0;
        c13_sample_in = 14'h0000;
        c13_sample_valid = 1'b0;
        do_reset();
        t_reset();
        t_power();
        t_pattern();
        t_c13();
        do_reset();
        t_reset();
        complete_run();
    end
endmodule : cpgo_regs_tb
